// ---- shared/ib_map.svh ----
/*
  Bus constants for the instrument bus device port: address groups,
  command codes, buffer shape and handshake timing.
  Assumes a 50 ns logic clock; included by bare name.
*/
`ifndef IB_MAP_SVH
`define IB_MAP_SVH

// ------------------------------------------------------------
// Address groups and command codes (7-bit, top data line ignored)
// ------------------------------------------------------------
`define IB_LAG_BASE   7'h20
`define IB_TAG_BASE   7'h40
`define IB_SEC_GRP    7'h60
`define IB_GRP_MASK   7'h60
`define IB_CMD_UNL    7'h3f
`define IB_CMD_UNT    7'h5f
`define IB_CMD_GET    7'h08
`define IB_CMD_DCL    7'h14
`define IB_CMD_SDC    7'h04
`define IB_ADDR_MAX   5'h1e

// ------------------------------------------------------------
// Buffer shape and timing
// ------------------------------------------------------------
`define IB_FIFO_DEPTH 32
`define IB_FIFO_WIDTH 9
`define IB_CLK_NS     50
`define IB_SETTLE_NS  100
`define IB_SETTLE_CYC ((`IB_SETTLE_NS + `IB_CLK_NS - 1) / `IB_CLK_NS)

`endif

// ---- shared/ib_pkg.sv ----
/*
  Types shared by the instrument bus device port modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package ib_pkg;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } ib_byte_t;

  // Handshake line levels, 1 = true (line pulled low)
  typedef struct packed {
    logic dav;
    logic nrfd;
    logic ndac;
  } hs_t;

  // ------------------------------------------------------------
  // State machines
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ACC_IDLE, ACC_READY, ACC_HOLD} acc_state_t;
  typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_VALID, SRC_RELEASE} src_state_t;

endpackage

`default_nettype wire

// ---- logic/ib_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides and a flush.
  Assumes one clock, synchronous active-high reset, DEPTH a power of two.
*/
`include "ib_map.svh"
`default_nettype none

module ib_fifo
  import ib_pkg::*;
#(
  parameter int WIDTH = `IB_FIFO_WIDTH,
  parameter int DEPTH = `IB_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------
  // Pointers wrap by overflow, hence the power-of-two depth
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             rdy_r, rdy_nxt;
  logic             push, pop;

  assign push        = in_valid_i && rdy_r;
  assign pop         = out_ready_i && (cnt_r != '0);
  assign in_ready_o  = rdy_r;
  assign out_valid_o = cnt_r != '0;
  assign out_data_o  = mem_r[rd_r];

  always_comb begin
    wr_nxt  = push ? wr_r + 1'b1 : wr_r;
    rd_nxt  = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    if (flush_i) begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
    end
    // Ready is registered so the source sees an honest full flag
    rdy_nxt = cnt_nxt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// ---- logic/ib_source.sv ----
/*
  Source side of the three-wire byte handshake: places a byte, waits
  for all acceptors, marks it valid and pops it once accepted.
  Assumes line levels already converted to true/false.
*/
`include "ib_map.svh"
`default_nettype none

module ib_source
  import ib_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire hs_t        hs_i,
  input  wire ib_byte_t   fifo_data_i,
  input  wire logic       fifo_valid_i,
  output logic            fifo_pop_o,
  output logic            dav_oe_o,
  output logic            eoi_oe_o,
  output logic      [7:0] dio_oe_o
);

  src_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       dav_r, dav_nxt, eoi_r, eoi_nxt;
  logic [7:0] dio_r, dio_nxt;

  assign dav_oe_o = dav_r;
  assign eoi_oe_o = eoi_r;
  assign dio_oe_o = dio_r;

  // ------------------------------------------------------------
  // Handshake sequence
  // ------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    dav_nxt    = dav_r;
    eoi_nxt    = eoi_r;
    dio_nxt    = dio_r;
    fifo_pop_o = 1'b0;
    case (state_r)
      SRC_IDLE: begin
        if (enable_i && fifo_valid_i) begin
          dio_nxt   = fifo_data_i.data;
          eoi_nxt   = fifo_data_i.last;
          cnt_nxt   = 2'(`IB_SETTLE_CYC);
          state_nxt = SRC_SETTLE;
        end
      end
      SRC_SETTLE: begin
        // Data must settle before it is marked valid
        if (cnt_r != 2'h0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (!hs_i.nrfd && hs_i.ndac) begin
          dav_nxt   = 1'b1;
          state_nxt = SRC_VALID;
        end
      end
      SRC_VALID: begin
        if (!hs_i.ndac) begin
          dav_nxt    = 1'b0;
          fifo_pop_o = 1'b1;
          state_nxt  = SRC_RELEASE;
        end
      end
      SRC_RELEASE: begin
        dio_nxt   = 8'h00;
        eoi_nxt   = 1'b0;
        state_nxt = SRC_IDLE;
      end
      default: begin
        state_nxt = SRC_IDLE;
      end
    endcase
    // Losing the talker role, or attention or interface clear going true, drops the lines at once;
    // an unaccepted byte stays queued for the next turn
    if (!enable_i) begin
      dav_nxt   = 1'b0;
      eoi_nxt   = 1'b0;
      dio_nxt   = 8'h00;
      state_nxt = SRC_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SRC_IDLE;
      cnt_r   <= 2'h0;
      dav_r   <= 1'b0;
      eoi_r   <= 1'b0;
      dio_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      dav_r   <= dav_nxt;
      eoi_r   <= eoi_nxt;
      dio_r   <= dio_nxt;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  dav_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(dav_r) |-> $past(!hs_i.nrfd && hs_i.ndac))
    else $error("Data valid raised while acceptors not ready");

  dav_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dav_r && !hs_i.ndac |=> !dav_r)
    else $error("Data valid held after acceptance");

  one_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_pop_o |-> dav_r && !hs_i.ndac)
    else $error("Byte popped without a complete handshake");

endmodule

`default_nettype wire

// ---- logic/ib_device.sv ----
/*
  Device end of the instrument bus: address decode, command handling,
  acceptor and source handshakes, queued talker output.
  Assumes all bus inputs synchronous to REF_CLK_I; open-drain lines are
  resolved outside from the output enables.
*/
// Behaviour
// - Primary address 0 to 30 sets bus addresses; 31 disables addressing.
// - Listen address is primary address ORed with 20 hex.
// - Talk address is primary address ORed with 40 hex.
// - Bytes 60 to 7F hex under attention are secondary, never ours.
// - Only one talker at a time; listeners may be many.
// - As talker, send the queued data one byte per handshake.
// - Every bus line is true when low.
// - Eight shared data lines carry data, addresses and commands, low true.
// - Byte under attention is address or command, otherwise device data.
// - Interface clear returns talker and listener to idle.
// - Remote enable true puts the device in remote operation.
// - End line marks the last byte, both sent and received.
// - Service request line asserted when the device needs attention.
// - Source drives data valid; acceptors drive the two ready lines.
// - Source waits for ready-for-data and data-not-accepted before valid.
// - Acceptor lines settle promptly after attention becomes true.
// - Source marks valid; acceptor then holds off further data.
// - Acceptor releases not-accepted after taking the byte.
// - Unlisten command makes the device listener idle.
// - Untalk command makes the device talker idle.
// - Group execute trigger starts the trigger action.
// - Device clear, or selective clear while listener, restores defaults.
`include "ib_map.svh"
`default_nettype none

module ib_device
  import ib_pkg::*;
(
  input  wire logic       REF_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic [7:0] DIO_N_I,
  output logic      [7:0] DIO_N_O,
  output logic      [7:0] DIO_N_OE,
  input  wire logic       ATN_N_I,
  input  wire logic       IFC_N_I,
  input  wire logic       REN_N_I,
  input  wire logic       EOI_N_I,
  output logic            EOI_N_O,
  output logic            EOI_N_OE,
  output logic            SRQ_N_O,
  output logic            SRQ_N_OE,
  input  wire logic       DAV_N_I,
  output logic            DAV_N_O,
  output logic            DAV_N_OE,
  input  wire logic       NRFD_N_I,
  output logic            NRFD_N_O,
  output logic            NRFD_N_OE,
  input  wire logic       NDAC_N_I,
  output logic            NDAC_N_O,
  output logic            NDAC_N_OE,
  input  wire logic [4:0] PRIMARY_ADDR_I,
  input  wire logic [7:0] TX_DATA_I,
  input  wire logic       TX_LAST_I,
  input  wire logic       TX_VALID_I,
  output logic            TX_READY_O,
  output logic      [7:0] RX_DATA_O,
  output logic            RX_LAST_O,
  output logic            RX_VALID_O,
  input  wire logic       SERVICE_REQ_I,
  output logic            LISTEN_O,
  output logic            TALK_O,
  output logic            REMOTE_O,
  output logic            TRIGGER_O,
  output logic            DEV_CLEAR_O
);

  // ------------------------------------------------------------
  // Line levels, true when the wire is low
  // ------------------------------------------------------------
  logic       atn_t, ifc_t, ren_t, dav_t, addr_ok, participate;
  logic [6:0] my_lag, my_tag, cmd;
  hs_t        hs;

  assign atn_t   = ~ATN_N_I;
  assign ifc_t   = ~IFC_N_I;
  assign ren_t   = ~REN_N_I;
  assign dav_t   = ~DAV_N_I;
  assign hs      = '{dav: ~DAV_N_I, nrfd: ~NRFD_N_I, ndac: ~NDAC_N_I};
  // Address 31 would alias the unlisten and untalk codes
  assign addr_ok = PRIMARY_ADDR_I <= `IB_ADDR_MAX;
  assign my_lag  = `IB_LAG_BASE | {2'b00, PRIMARY_ADDR_I};
  assign my_tag  = `IB_TAG_BASE | {2'b00, PRIMARY_ADDR_I};

  // ------------------------------------------------------------
  // Acceptor handshake
  // ------------------------------------------------------------
  acc_state_t acc_r, acc_nxt;
  ib_byte_t   byte_r, byte_nxt;
  logic       batn_r, batn_nxt, take_r, take_nxt;
  logic       nrfd_r, nrfd_nxt, ndac_r, ndac_nxt;
  logic       listen_r, listen_nxt;

  // Every device takes part under attention; data only when listening
  assign participate = (atn_t || listen_r) && !ifc_t;

  always_comb begin
    acc_nxt  = acc_r;
    byte_nxt = byte_r;
    batn_nxt = batn_r;
    take_nxt = 1'b0;
    nrfd_nxt = nrfd_r;
    ndac_nxt = ndac_r;
    case (acc_r)
      ACC_IDLE: begin
        if (participate) begin
          ndac_nxt = 1'b1;
          nrfd_nxt = 1'b0;
          acc_nxt  = ACC_READY;
        end
      end
      ACC_READY: begin
        if (dav_t) begin
          byte_nxt = '{last: ~EOI_N_I, data: ~DIO_N_I};
          batn_nxt = atn_t;
          take_nxt = 1'b1;
          nrfd_nxt = 1'b1;
          acc_nxt  = ACC_HOLD;
        end
      end
      ACC_HOLD: begin
        if (ndac_r) begin
          ndac_nxt = 1'b0;
        end else if (!dav_t) begin
          ndac_nxt = 1'b1;
          nrfd_nxt = 1'b0;
          acc_nxt  = ACC_READY;
        end
      end
      default: begin
        acc_nxt = ACC_IDLE;
      end
    endcase
    // A device that is not taking part must not hold the lines
    if (!participate) begin
      nrfd_nxt = 1'b0;
      ndac_nxt = 1'b0;
      acc_nxt  = ACC_IDLE;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      acc_r  <= ACC_IDLE;
      byte_r <= '0;
      batn_r <= 1'b0;
      take_r <= 1'b0;
      nrfd_r <= 1'b0;
      ndac_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      byte_r <= byte_nxt;
      batn_r <= batn_nxt;
      take_r <= take_nxt;
      nrfd_r <= nrfd_nxt;
      ndac_r <= ndac_nxt;
    end
  end

  // ------------------------------------------------------------
  // Roles and command decode
  // ------------------------------------------------------------
  logic       talk_r, talk_nxt, remote_r, remote_nxt, srq_r, srq_nxt;
  logic       trig_r, trig_nxt, clr_r, clr_nxt, rxv_r, rxv_nxt;
  ib_byte_t   rx_r, rx_nxt;

  assign cmd = byte_r.data[6:0];

  always_comb begin
    listen_nxt = listen_r;
    talk_nxt   = talk_r;
    trig_nxt   = 1'b0;
    clr_nxt    = 1'b0;
    rxv_nxt    = 1'b0;
    rx_nxt     = rx_r;
    remote_nxt = ren_t;
    srq_nxt    = SERVICE_REQ_I;
    if (take_r && batn_r) begin
      if ((cmd & `IB_GRP_MASK) != `IB_SEC_GRP) begin
        if (addr_ok && cmd == my_lag) begin
          listen_nxt = 1'b1;
        end else if (cmd == `IB_CMD_UNL) begin
          listen_nxt = 1'b0;
        end
        if (addr_ok && cmd == my_tag) begin
          talk_nxt = 1'b1;
        end else if ((cmd & `IB_GRP_MASK) == `IB_TAG_BASE) begin
          talk_nxt = 1'b0;
        end
        if (cmd == `IB_CMD_GET) begin
          trig_nxt = 1'b1;
        end
        if (cmd == `IB_CMD_DCL || (cmd == `IB_CMD_SDC && listen_r)) begin
          clr_nxt = 1'b1;
        end
      end
    end else if (take_r && listen_r) begin
      rxv_nxt = 1'b1;
      rx_nxt  = byte_r;
    end
    if (ifc_t) begin
      listen_nxt = 1'b0;
      talk_nxt   = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      listen_r <= 1'b0;
      talk_r   <= 1'b0;
      remote_r <= 1'b0;
      srq_r    <= 1'b0;
      trig_r   <= 1'b0;
      clr_r    <= 1'b0;
      rxv_r    <= 1'b0;
      rx_r     <= '0;
    end else begin
      listen_r <= listen_nxt;
      talk_r   <= talk_nxt;
      remote_r <= remote_nxt;
      srq_r    <= srq_nxt;
      trig_r   <= trig_nxt;
      clr_r    <= clr_nxt;
      rxv_r    <= rxv_nxt;
      rx_r     <= rx_nxt;
    end
  end

  // ------------------------------------------------------------
  // Talker path: queue then source handshake
  // ------------------------------------------------------------
  ib_byte_t q_data;
  logic     q_valid, q_pop, src_dav, src_eoi;
  logic [7:0] src_dio;

  // Device clear discards queued output, as at power-up
  ib_fifo #(.WIDTH(`IB_FIFO_WIDTH), .DEPTH(`IB_FIFO_DEPTH)) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_i       (SYS_RST_I),
    .flush_i     (clr_r),
    .in_data_i   ({TX_LAST_I, TX_DATA_I}),
    .in_valid_i  (TX_VALID_I),
    .in_ready_o  (TX_READY_O),
    .out_data_o  (q_data),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop)
  );

  ib_source u_source (
    .clk_i        (REF_CLK_I),
    .rst_i        (SYS_RST_I),
    .enable_i     (talk_r && !atn_t && !ifc_t),
    .hs_i         (hs),
    .fifo_data_i  (q_data),
    .fifo_valid_i (q_valid),
    .fifo_pop_o   (q_pop),
    .dav_oe_o     (src_dav),
    .eoi_oe_o     (src_eoi),
    .dio_oe_o     (src_dio)
  );

  // ------------------------------------------------------------
  // Pins: open drain, so the driven level is always low
  // ------------------------------------------------------------
  logic [12:0] low_r;

  always_ff @(posedge REF_CLK_I) begin
    low_r <= 13'h0000;
  end

  assign DIO_N_O     = low_r[7:0];
  assign EOI_N_O     = low_r[8];
  assign SRQ_N_O     = low_r[9];
  assign DAV_N_O     = low_r[10];
  assign NRFD_N_O    = low_r[11];
  assign NDAC_N_O    = low_r[12];
  assign DIO_N_OE    = src_dio;
  assign EOI_N_OE    = src_eoi;
  assign DAV_N_OE    = src_dav;
  assign NRFD_N_OE   = nrfd_r;
  assign NDAC_N_OE   = ndac_r;
  assign SRQ_N_OE    = srq_r;
  assign RX_DATA_O   = rx_r.data;
  assign RX_LAST_O   = rx_r.last;
  assign RX_VALID_O  = rxv_r;
  assign LISTEN_O    = listen_r;
  assign TALK_O      = talk_r;
  assign REMOTE_O    = remote_r;
  assign TRIGGER_O   = trig_r;
  assign DEV_CLEAR_O = clr_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  addr_valid_a: assert property ($rose(listen_r) |-> $past(addr_ok))
    else $error("Listener role taken with an invalid address");
  listen_addr_a: assert property (take_r && batn_r && addr_ok && cmd == my_lag
    && !ifc_t |=> listen_r)
    else $error("Own listen address not obeyed");
  talk_addr_a: assert property (take_r && batn_r && addr_ok && cmd == my_tag
    && !ifc_t |=> talk_r)
    else $error("Own talk address not obeyed");
  sec_ignore_a: assert property (take_r && batn_r && (cmd & `IB_GRP_MASK) == `IB_SEC_GRP
    && !ifc_t |=> $stable({listen_r, talk_r}) && !trig_r && !clr_r)
    else $error("Secondary address changed the device");
  ifc_idle_a: assert property (ifc_t |=> !listen_r && !talk_r ##1 !nrfd_r)
    else $error("Interface clear did not idle the device");
  remote_on_a: assert property (ren_t |=> remote_r)
    else $error("Remote enable not followed");
  unlisten_cmd_a: assert property (take_r && batn_r && cmd == `IB_CMD_UNL
    |=> !listen_r)
    else $error("Unlisten did not idle the listener");
  untalk_cmd_a: assert property (take_r && batn_r && cmd == `IB_CMD_UNT
    |=> !talk_r)
    else $error("Untalk did not idle the talker");
  trigger_pulse_a: assert property (take_r && batn_r && cmd == `IB_CMD_GET
    |=> trig_r ##1 !trig_r)
    else $error("Trigger not a single pulse");
  rx_data_a: assert property (rxv_r |-> $past(take_r && !batn_r && listen_r))
    else $error("Data delivered outside a data byte");
  atn_ready_a: assert property (atn_t && !ifc_t && acc_r == ACC_IDLE
    |=> ndac_r && !nrfd_r)
    else $error("Acceptor slow to answer attention");
  accept_seq_a: assert property (acc_r == ACC_READY && dav_t && participate
    |=> nrfd_r && ndac_r ##1 !ndac_r)
    else $error("Acceptor handshake out of order");

endmodule

`default_nettype wire

// ---- verification/ib_ctrl_model.sv ----
/* Bus controller model: sources commands and data, listens as the sole acceptor.
   Assumes the bench resolves the wired lines and hands back true handshake levels; data and EOI come back as wire levels. */
`default_nettype none
module ib_ctrl_model
  import ib_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] dio_n_i,
  input  wire logic       eoi_n_i,
  input  wire hs_t        hs_i,
  output logic            atn_o,
  output logic            ifc_o,
  output logic            ren_o,
  output logic      [7:0] dio_o,
  output logic            eoi_o,
  output hs_t             hs_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stall;  // Stuck handshake is flagged after 40 cycles, never hangs
  initial {atn_o, ifc_o, ren_o, dio_o, eoi_o, hs_o, stall} = '0;
  task automatic hold(input logic [2:0] m, input logic [2:0] v);
    for (int n = 0; n < 40 && (hs_i & m) != v; n++) @(negedge clk_i);
    stall |= (hs_i & m) != v;
  endtask
  // Outputs are pull-low enables, 1 = line true
  task automatic send(input logic a, input logic [7:0] d, input logic l);
    @(negedge clk_i);
    {stall, hs_o, atn_o, dio_o, eoi_o} = {4'h0, a, d, l};
    repeat (3) @(negedge clk_i);  // Acceptors settle over 100 ns
    hold(3'b011, 3'b001);
    hs_o.dav = !stall;
    hold(3'b001, 3'b000);
    hs_o.dav = 1'b0;
    @(negedge clk_i);
    {dio_o, eoi_o} = '0;
  endtask
  // Listens only, never talks; slow sets its release pace
  task automatic recv(input int slow, output logic [8:0] b);
    @(negedge clk_i);
    {stall, atn_o, hs_o} = 5'h01;
    hold(3'b100, 3'b100);
    b = {~eoi_n_i, ~dio_n_i};
    hs_o.nrfd = 1'b1;
    // At least one edge between pulling ready low and releasing accepted
    repeat (slow + 1) @(negedge clk_i);
    hs_o.ndac = 1'b0;
    hold(3'b100, 3'b000);
    hs_o = 3'b001;
  endtask
  task automatic uni(input int i, input int r);
    @(negedge clk_i);
    {ifc_o, ren_o} = {i[0], r[0]};
  endtask
endmodule
`default_nettype wire

// ---- verification/ib_device_tb.sv ----
/* Self-checking bench of the instrument bus device port.
   Assumes the controller model as far side; wired lines are resolved here. */
`default_nettype none
module ib_device_tb;
  import ib_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst = 1, srq = 0, tx_v = 0, tx_l = 0;
  logic [4:0] pa = 5'h0a;
  logic [7:0] tx_d = 8'h00, d_o, d_oe, c_dio, rx_d;
  logic       e_o, e_oe, v_o, v_oe, r_o, r_oe, a_o, a_oe, srq_oe, tx_rdy, rx_v, rx_l;
  logic       c_atn, c_ifc, c_ren, c_eoi, lis, tlk, rem, trg, clr, srq_o;
  hs_t        c_hs;
  int         errors = 0, check_count = 0, cyc = 0, trig_n = 0, clr_n = 0;
  logic [8:0] rxq[$];
  // Released lines float high on the pull-ups
  wire logic [7:0] dio_n = ~(d_oe & ~d_o) & ~c_dio;
  wire logic eoi_n = ~(e_oe & ~e_o) & ~c_eoi;
  wire hs_t hs = {v_oe & ~v_o | c_hs.dav, r_oe & ~r_o | c_hs.nrfd, a_oe & ~a_o | c_hs.ndac};
  ib_device ib_device_i (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .DIO_N_I(dio_n), .DIO_N_O(d_o), .DIO_N_OE(d_oe),
    .ATN_N_I(~c_atn), .IFC_N_I(~c_ifc), .REN_N_I(~c_ren), .EOI_N_I(eoi_n), .EOI_N_O(e_o),
    .EOI_N_OE(e_oe), .SRQ_N_O(srq_o), .SRQ_N_OE(srq_oe), .DAV_N_I(~hs.dav), .DAV_N_O(v_o),
    .DAV_N_OE(v_oe), .NRFD_N_I(~hs.nrfd), .NRFD_N_O(r_o), .NRFD_N_OE(r_oe),
    .NDAC_N_I(~hs.ndac), .NDAC_N_O(a_o), .NDAC_N_OE(a_oe), .PRIMARY_ADDR_I(pa),
    .TX_DATA_I(tx_d), .TX_LAST_I(tx_l), .TX_VALID_I(tx_v), .TX_READY_O(tx_rdy),
    .RX_DATA_O(rx_d), .RX_LAST_O(rx_l), .RX_VALID_O(rx_v), .SERVICE_REQ_I(srq),
    .LISTEN_O(lis), .TALK_O(tlk), .REMOTE_O(rem), .TRIGGER_O(trg), .DEV_CLEAR_O(clr));
  ib_ctrl_model ctl_i (.clk_i(clk), .dio_n_i(dio_n), .eoi_n_i(eoi_n), .hs_i(hs),
    .atn_o(c_atn), .ifc_o(c_ifc), .ren_o(c_ren), .dio_o(c_dio), .eoi_o(c_eoi), .hs_o(c_hs));
  always #25 clk = ~clk;
  // Pulses are sampled mid-cycle, clear of the edge that launches them
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (rx_v === 1'b1) rxq.push_back({rx_l, rx_d});
    if (trg === 1'b1) trig_n <= trig_n + 1;
    if (clr === 1'b1) clr_n <= clr_n + 1;
    if (cyc == 20000) begin  // Run needs about 530 cycles; margin over thirtyfold
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic snd(input int a, input logic [7:0] d, input int l, input int st);
    ctl_i.send(a[0], d, l[0]);
    chk("stall", 9'(ctl_i.stall), 9'(st));
  endtask
  task automatic t_addr();
    logic [4:0] v[3] = '{5'h00, 5'h0a, 5'h1e};
    foreach (v[i]) begin
      pa = v[i];
      snd(1, {3'b011, pa}, 0, 0);
      chk("secondary", 9'(lis), 9'h0);
      snd(1, {3'b001, pa}, 0, 0);
      chk("listen", 9'(lis), 9'h1);
      snd(1, 8'h3f, 0, 0);
      chk("unlisten", 9'(lis), 9'h0);
    end
    pa = 5'h1f;
    snd(1, 8'h3f, 0, 0);
    chk("no address", 9'(lis), 9'h0);
    $display("addr test done");
  endtask
  task automatic t_rx();
    snd(0, 8'h11, 0, 1);
    snd(1, {3'b001, pa}, 0, 0);
    rxq.delete();
    snd(0, 8'h5a, 0, 0);
    snd(0, 8'ha5, 1, 0);
    chk("rx first", rxq[0], 9'h05a);
    chk("rx last", rxq[1], 9'h1a5);
    snd(1, 8'h3f, 0, 0);
    $display("rx test done");
  endtask
  task automatic t_tx();
    logic [8:0] b;
    for (int i = 0; i < 32; i++) begin
      {tx_v, tx_l, tx_d} = {1'b1, i == 31, 8'(i * 7 + 1)};
      @(negedge clk);
    end
    tx_v = 0;
    chk("fifo full", 9'(tx_rdy), 9'h0);
    snd(1, {3'b010, pa}, 0, 0);
    for (int i = 0; i < 32; i++) begin
      ctl_i.recv(i % 3, b);
      chk("tx byte", b, {i == 31, 8'(i * 7 + 1)});
    end
    wt(2);
    chk("fifo empty", 9'(tx_rdy), 9'h1);
    snd(1, {3'b010, pa + 5'h01}, 0, 0);
    chk("other talker", 9'(tlk), 9'h0);
    snd(1, {3'b010, pa}, 0, 0);
    snd(1, 8'h5f, 0, 0);
    chk("untalk", 9'(tlk), 9'h0);
    $display("tx test done");
  endtask
  task automatic t_ctl();
    int t = trig_n;
    int c = clr_n;
    snd(1, 8'h08, 0, 0);
    snd(1, 8'h04, 0, 0);
    snd(1, 8'h14, 0, 0);
    snd(1, {3'b001, pa}, 0, 0);
    snd(1, 8'h04, 0, 0);
    snd(1, {3'b010, pa}, 0, 0);
    chk("trigger", 9'(trig_n - t), 9'h1);
    chk("clear", 9'(clr_n - c), 9'h2);
    chk("roles", 9'({lis, tlk}), 9'h3);
    ctl_i.uni(1, 1);
    srq = 1;
    wt(3);
    chk("ifc ren srq", 9'({rem, srq_oe, srq_o, lis, tlk}), 9'h018);
    ctl_i.uni(0, 0);
    srq = 0;
    wt(3);
    chk("ren srq off", 9'({rem, srq_oe}), 9'h0);
    $display("ctl test done");
  endtask
  initial begin
    wt(12);
    rst = 0;
    wt(2);
    chk("after reset", 9'({lis, tlk, tx_rdy}), 9'h1);
    t_addr();
    pa = 5'h0a;
    t_rx();
    t_tx();
    t_ctl();
    print_verdict();
  end
endmodule
`default_nettype wire
